/* File: include/mpp_pkg.sv */
// Constants shared by the port pin block
package mpp_pkg;
  // ------------------------------------------------------------
  // Data memory addresses
  // ------------------------------------------------------------
  localparam logic [7:0] MPP_ADDR_WAKE_EN   = 8'hc9;
  localparam logic [7:0] MPP_ADDR_CTL_TWO   = 8'hcc;
  localparam logic [7:0] MPP_ADDR_L_DATA    = 8'hd0;
  localparam logic [7:0] MPP_ADDR_L_CFG     = 8'hd1;
  localparam logic [7:0] MPP_ADDR_L_PINS    = 8'hd2;
  localparam logic [7:0] MPP_ADDR_G_DATA    = 8'hd4;
  localparam logic [7:0] MPP_ADDR_G_CFG     = 8'hd5;
  localparam logic [7:0] MPP_ADDR_G_PINS    = 8'hd6;
  localparam logic [7:0] MPP_ADDR_D_DATA    = 8'hdc;
  localparam logic [7:0] MPP_ADDR_CTL_ONE   = 8'hee;
  localparam logic [7:0] MPP_ADDR_STATUS    = 8'hef;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] MPP_RST_BYTE       = 8'h00;
  localparam logic [3:0] MPP_RST_D_PORT     = 4'hf;
  localparam logic [7:0] MPP_RD_UNMAPPED    = 8'h00;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam logic [7:0] MPP_G_IN_ONLY_MASK = 8'hc0;
  localparam int         MPP_G_HALT_BIT     = 7;
  localparam int         MPP_CT2_CMP_EN     = 0;
  localparam int         MPP_CT2_COMPARATOR_RESULT_OUTPUT_EN  = 1;
  localparam int         MPP_CT2_MOD_EN     = 2;
  localparam int         MPP_CT1_SER_EN     = 0;
  localparam int         MPP_CT1_SER_MASTER = 1;
  localparam int         MPP_CT1_TMR_OUT    = 2;
  localparam int         MPP_ST_EXT_INT_EN  = 0;
endpackage

/* File: verilog/mpp_pin_cell.sv */
// One bidirectional pin: mode decode with alternate function override
`timescale 1ns/10ps
`default_nettype none
module mpp_pin_cell (
  // Latches
  input  wire logic cfg_in,
  input  wire logic data_in,
  // Alternate function
  input  wire logic alt_en_in,
  input  wire logic alt_drive_in,
  input  wire logic alt_val_in,
  // Pad controls
  output logic      oe_out,
  output logic      out_out,
  output logic      pullup_out
);
  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  always_comb begin
    if (alt_en_in) begin
      // Alternate input functions want a clean hi-z pad
      oe_out     = alt_drive_in;
      out_out    = alt_drive_in & alt_val_in;
      pullup_out = 1'b0;
    end else begin
      oe_out     = cfg_in;
      out_out    = cfg_in & data_in;
      pullup_out = ~cfg_in & data_in;
    end
  end
endmodule // mpp_pin_cell
`default_nettype wire

/* File: verilog/mpp_port_pins.sv */
// Parallel port block: two 8-bit ports, output port, input port, pin routing
`timescale 1ns/10ps
`default_nettype none
// Contract
// - First port pin mode from config/data: hi-z, pull-up, drive low, drive high.
// - First port data at d0, config at d1, pin image at d2.
// - Second port uses the same per-bit config/data encoding.
// - Second port data at d4, config at d5, pin image at d6.
// - Second port bits 6 and 7 config ignore ones and read zero.
// - Writing one to second port data bit 7 requests halt.
// - Four-bit output port latch at dc, preset high at reset.
// - Four-bit input port pins are always hi-z, no drivers or pull-ups.
// - Wake-up enable at c9; comparator and modulator selects at cc.
// - Second port: 6 serial in, 5 serial clock, 4 serial out, 3 timer, 0 interrupt.
// - Second port pin 7 is oscillator output or halt-restart input.
// - Interrupt enable in status at ef; timer and serial selects at ee.
// - Second port pins 2 and 1 are plain general-purpose I/O.
// - Reset clears both 8-bit ports to hi-z, except second port pin 7 with crystal option set, and drives output port high.
module mpp_port_pins
  import mpp_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  // Data memory access
  input  wire logic [7:0]   addr_in,
  input  wire logic [7:0]   wdata_in,
  input  wire logic         wr_en_in,
  input  wire logic         rd_en_in,
  output logic [7:0]        rdata_out,
  // First port pad
  input  wire logic [W-1:0] first_pins_in,
  output logic [W-1:0]      first_pins_out,
  output logic [W-1:0]      first_pins_oe_out,
  output logic [W-1:0]      first_pullup_out,
  // Second port pad
  input  wire logic [W-1:0] second_pins_in,
  output logic [W-1:0]      second_pins_out,
  output logic [W-1:0]      second_pins_oe_out,
  output logic [W-1:0]      second_pullup_out,
  // Output and input ports
  output logic [3:0]        output_port_out,
  input  wire logic [3:0]   input_port_in,
  output logic [3:0]        input_port_level_out,
  // Peripheral side
  input  wire logic         modulator_output_in,
  input  wire logic         comparator_result_output_in,
  input  wire logic         oscillator_output_in,
  input  wire logic         crystal_option_in,
  input  wire logic         serial_data_out_in,
  input  wire logic         serial_clock_pin_in,
  input  wire logic         timer_pin_in,
  output logic [W-1:0]      multi_input_wakeup_out,
  output logic              comparator_plus_input_out,
  output logic              comparator_minus_input_out,
  output logic              serial_data_in_out,
  output logic              serial_clock_pin_out,
  output logic              timer_pin_out,
  output logic              external_interrupt_pin_out,
  output logic              halt_restart_out,
  output logic              halt_request_out
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0]   wakeup_enable_reg;
  logic [7:0]   control_two_reg;
  logic [7:0]   control_one_reg;
  logic [7:0]   processor_status_reg;
  logic [W-1:0] first_port_data;
  logic [W-1:0] first_port_config;
  logic [W-1:0] second_port_data;
  logic [W-1:0] second_port_config;
  logic [3:0]   output_port_data;
  logic [W-1:0] first_meta;
  logic [W-1:0] first_sync;
  logic [W-1:0] second_meta;
  logic [W-1:0] second_sync;
  logic [3:0]   input_meta;
  logic [3:0]   input_sync;
  logic [W-1:0] first_alt_en;
  logic [W-1:0] first_alt_drive;
  logic [W-1:0] first_alt_val;
  logic [W-1:0] second_alt_en;
  logic [W-1:0] second_alt_drive;
  logic [W-1:0] second_alt_val;
  logic [7:0]   next_rdata;
  logic         cmp_en;
  logic         ser_en;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wakeup_enable_reg    <= MPP_RST_BYTE;
      control_two_reg      <= MPP_RST_BYTE;
      control_one_reg      <= MPP_RST_BYTE;
      processor_status_reg <= MPP_RST_BYTE;
    end else if (wr_en_in) begin
      case (addr_in)
        MPP_ADDR_WAKE_EN: wakeup_enable_reg    <= wdata_in;
        MPP_ADDR_CTL_TWO: control_two_reg      <= wdata_in;
        MPP_ADDR_CTL_ONE: control_one_reg      <= wdata_in;
        MPP_ADDR_STATUS:  processor_status_reg <= wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      first_port_data    <= MPP_RST_BYTE;
      first_port_config  <= MPP_RST_BYTE;
      second_port_data   <= MPP_RST_BYTE;
      second_port_config <= MPP_RST_BYTE;
    end else if (wr_en_in) begin
      case (addr_in)
        MPP_ADDR_L_DATA: first_port_data   <= wdata_in;
        MPP_ADDR_L_CFG:  first_port_config <= wdata_in;
        MPP_ADDR_G_DATA: second_port_data  <= wdata_in;
        // Input-only bits never latch a one
        MPP_ADDR_G_CFG: second_port_config <= wdata_in & ~MPP_G_IN_ONLY_MASK;
        default: ;
      endcase
    end
  end

  // Preset is asynchronous so the pins go high as reset falls
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      output_port_data <= MPP_RST_D_PORT;
    end else if (wr_en_in && addr_in == MPP_ADDR_D_DATA) begin
      output_port_data <= wdata_in[3:0];
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      halt_request_out <= 1'b0;
    end else begin
      halt_request_out <= wr_en_in && addr_in == MPP_ADDR_G_DATA
                          && wdata_in[MPP_G_HALT_BIT];
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      first_meta  <= '0;
      first_sync  <= '0;
      second_meta <= '0;
      second_sync <= '0;
      input_meta  <= '0;
      input_sync  <= '0;
    end else begin
      first_meta  <= first_pins_in;
      first_sync  <= first_meta;
      second_meta <= second_pins_in;
      second_sync <= second_meta;
      input_meta  <= input_port_in;
      input_sync  <= input_meta;
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = MPP_RD_UNMAPPED;
    case (addr_in)
      MPP_ADDR_WAKE_EN: next_rdata = wakeup_enable_reg;
      MPP_ADDR_CTL_TWO: next_rdata = control_two_reg;
      MPP_ADDR_CTL_ONE: next_rdata = control_one_reg;
      MPP_ADDR_STATUS:  next_rdata = processor_status_reg;
      MPP_ADDR_L_DATA:  next_rdata = first_port_data;
      MPP_ADDR_L_CFG:   next_rdata = first_port_config;
      MPP_ADDR_L_PINS:  next_rdata = first_sync;
      MPP_ADDR_G_DATA:  next_rdata = second_port_data;
      MPP_ADDR_G_CFG:   next_rdata = second_port_config;
      MPP_ADDR_G_PINS:  next_rdata = second_sync;
      MPP_ADDR_D_DATA:  next_rdata = {4'h0, output_port_data};
      default:          next_rdata = MPP_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= MPP_RD_UNMAPPED;
    end else if (rd_en_in) begin
      rdata_out <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Alternate function routing
  // ------------------------------------------------------------
  assign cmp_en = control_two_reg[MPP_CT2_CMP_EN];
  assign ser_en = control_one_reg[MPP_CT1_SER_EN];

  always_comb begin
    first_alt_en    = {control_two_reg[MPP_CT2_MOD_EN], 4'h0, cmp_en, cmp_en,
                       control_two_reg[MPP_CT2_COMPARATOR_RESULT_OUTPUT_EN]};
    first_alt_drive = {control_two_reg[MPP_CT2_MOD_EN], 6'h00,
                       control_two_reg[MPP_CT2_COMPARATOR_RESULT_OUTPUT_EN]};
    first_alt_val   = {modulator_output_in, 6'h00, comparator_result_output_in};
    // Pins 2 and 1 stay on the latches alone
    second_alt_en    = {crystal_option_in, ser_en, ser_en, ser_en,
                        control_one_reg[MPP_CT1_TMR_OUT], 3'h0};
    second_alt_drive = {crystal_option_in, 1'b0,
                        ser_en & control_one_reg[MPP_CT1_SER_MASTER], ser_en,
                        control_one_reg[MPP_CT1_TMR_OUT], 3'h0};
    second_alt_val   = {oscillator_output_in, 1'b0, serial_clock_pin_in,
                        serial_data_out_in, timer_pin_in, 3'h0};
  end

  for (genvar i = 0; i < W; i++) begin : g_cell
    mpp_pin_cell u_first (
      .cfg_in       (first_port_config[i]),
      .data_in      (first_port_data[i]),
      .alt_en_in    (first_alt_en[i]),
      .alt_drive_in (first_alt_drive[i]),
      .alt_val_in   (first_alt_val[i]),
      .oe_out       (first_pins_oe_out[i]),
      .out_out      (first_pins_out[i]),
      .pullup_out   (first_pullup_out[i])
    );
    mpp_pin_cell u_second (
      .cfg_in       (second_port_config[i]),
      .data_in      (second_port_data[i]),
      .alt_en_in    (second_alt_en[i]),
      .alt_drive_in (second_alt_drive[i]),
      .alt_val_in   (second_alt_val[i]),
      .oe_out       (second_pins_oe_out[i]),
      .out_out      (second_pins_out[i]),
      .pullup_out   (second_pullup_out[i])
    );
  end

  // ------------------------------------------------------------
  // Input functions
  // ------------------------------------------------------------
  // Pulses shorter than one cycle may be missed by the sampler
  assign multi_input_wakeup_out     = first_sync & wakeup_enable_reg;
  assign comparator_plus_input_out  = cmp_en & first_sync[2];
  assign comparator_minus_input_out = cmp_en & first_sync[1];
  assign serial_data_in_out         = second_sync[6];
  assign serial_clock_pin_out       = second_sync[5];
  assign timer_pin_out              = second_sync[3];
  assign external_interrupt_pin_out = second_sync[0]
                                      & processor_status_reg[MPP_ST_EXT_INT_EN];
  assign halt_restart_out           = second_sync[7] & ~crystal_option_in;
  assign output_port_out            = output_port_data;
  // Input-only port has no pad drive at all
  assign input_port_level_out       = input_sync;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  property p_cfg_in_only;
    (second_port_config & MPP_G_IN_ONLY_MASK) == 8'h00;
  endproperty
  a_cfg_in_only: assert property (p_cfg_in_only) else $error("input-only config set");

  property p_halt_req;
    (wr_en_in && addr_in == MPP_ADDR_G_DATA && wdata_in[7]) |=> halt_request_out;
  endproperty
  a_halt_req: assert property (p_halt_req) else $error("halt request missing");

  property p_no_halt;
    !(wr_en_in && addr_in == MPP_ADDR_G_DATA && wdata_in[7]) |=> !halt_request_out;
  endproperty
  a_no_halt: assert property (p_no_halt) else $error("spurious halt request");

  property p_pullup;
    first_pullup_out == (~first_port_config & first_port_data & ~first_alt_en);
  endproperty
  a_pullup: assert property (p_pullup) else $error("first port pull-up wrong");

  property p_plain_gpio;
    second_pins_oe_out[2:1] == second_port_config[2:1]
    && second_pins_out[2:1] == (second_port_config[2:1] & second_port_data[2:1]);
  endproperty
  a_plain_gpio: assert property (p_plain_gpio) else $error("second port pins 2/1 wrong");

  property p_latch_read;
    (wr_en_in && addr_in == MPP_ADDR_L_DATA) ##1 !wr_en_in
    ##1 (rd_en_in && !wr_en_in && addr_in == MPP_ADDR_L_DATA)
    |=> rdata_out == $past(wdata_in, 3);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch readback wrong");

  property p_pin_image;
    (rd_en_in && addr_in == MPP_ADDR_G_PINS) |=> rdata_out == $past(second_sync);
  endproperty
  a_pin_image: assert property (p_pin_image) else $error("pin image wrong");

  property p_out_port;
    (wr_en_in && addr_in == MPP_ADDR_D_DATA) |=> output_port_out == $past(wdata_in[3:0]);
  endproperty
  a_out_port: assert property (p_out_port) else $error("output port not updated");

  property p_sync_delay;
    first_sync == $past(first_pins_in, 2) || $past(!rstn_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

  property p_ext_int;
    external_interrupt_pin_out |-> processor_status_reg[MPP_ST_EXT_INT_EN] && second_sync[0];
  endproperty
  a_ext_int: assert property (p_ext_int) else $error("interrupt ungated");

  c_halt: cover property (halt_request_out);
  c_wake: cover property (multi_input_wakeup_out != 8'h00);
  c_mod:  cover property (first_alt_drive[7] && first_pins_oe_out[7]);
  c_drive_high: cover property (first_pins_oe_out[0] && first_pins_out[0]);
endmodule // mpp_port_pins
`default_nettype wire

/* File: tb/mpp_board.sv */
// Board circuitry model on the port pads
`timescale 1ns/10ps
`default_nettype none
module mpp_board #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         clock_in,
  // Pad controls from the block
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] out_in,
  input  wire logic [W-1:0] pullup_in,
  // External sources on the board
  input  wire logic [W-1:0] ext_en_in,
  input  wire logic [W-1:0] ext_val_in,
  // Resolved pad level
  output logic [W-1:0]      level_out
);
  // ------------------------------------------------------------
  // Floating pads
  // ------------------------------------------------------------
  // Undriven pads wander, so a missing drive never reads as a constant
  logic flip = 1'b0;
  always @(posedge clock_in) flip <= ~flip;
  // ------------------------------------------------------------
  // Resolution
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe_in[i]) level_out[i] = out_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pullup_in[i]) level_out[i] = 1'b1;
      else level_out[i] = flip ^ i[0];
    end
  end
endmodule // mpp_board
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the port pin block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mpp_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic       clock_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_en_in = 1'b0;
  logic       rd_en_in = 1'b0;
  logic [7:0] rdata_out;
  logic [7:0] f_out, f_oe, f_pu, f_lvl, f_en = 8'h00, f_val = 8'h00;
  logic [7:0] s_out, s_oe, s_pu, s_lvl, s_en = 8'h00, s_val = 8'h00;
  logic [3:0] dport, in_val = 4'h0, in_sync;
  logic       mod_src = 1'b0, cmp_src = 1'b1, osc_src = 1'b1, xtal = 1'b0;
  logic       sdo_src = 1'b1, sck_src = 1'b0, tmr_src = 1'b1;
  logic [7:0] wake;
  logic       cmp_p, cmp_m, sdi, sck, tmr, xint, hrst, halt;
  int         fails = 0;
  int         checks = 0;
  int         cycles = 0;
  always #2.5 clock_in = ~clock_in;
  // ------------------------------------------------------------
  // Design and board
  // ------------------------------------------------------------
  mpp_port_pins #(.W(8)) dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rdata_out(rdata_out),
    .first_pins_in(f_lvl), .first_pins_out(f_out), .first_pins_oe_out(f_oe),
    .first_pullup_out(f_pu), .second_pins_in(s_lvl), .second_pins_out(s_out),
    .second_pins_oe_out(s_oe), .second_pullup_out(s_pu), .output_port_out(dport),
    .input_port_in(in_val), .input_port_level_out(in_sync),
    .modulator_output_in(mod_src), .comparator_result_output_in(cmp_src),
    .oscillator_output_in(osc_src), .crystal_option_in(xtal),
    .serial_data_out_in(sdo_src), .serial_clock_pin_in(sck_src),
    .timer_pin_in(tmr_src), .multi_input_wakeup_out(wake),
    .comparator_plus_input_out(cmp_p), .comparator_minus_input_out(cmp_m),
    .serial_data_in_out(sdi), .serial_clock_pin_out(sck), .timer_pin_out(tmr),
    .external_interrupt_pin_out(xint), .halt_restart_out(hrst),
    .halt_request_out(halt));
  mpp_board #(.W(8)) brd_first (.clock_in(clock_in), .oe_in(f_oe), .out_in(f_out),
    .pullup_in(f_pu), .ext_en_in(f_en), .ext_val_in(f_val), .level_out(f_lvl));
  mpp_board #(.W(8)) brd_second (.clock_in(clock_in), .oe_in(s_oe), .out_in(s_out),
    .pullup_in(s_pu), .ext_en_in(s_en), .ext_val_in(s_val), .level_out(s_lvl));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr_in = a;
    wdata_in = d;
    wr_en_in = 1'b1;
    @(negedge clock_in);
    wr_en_in = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    addr_in = a;
    rd_en_in = 1'b1;
    @(negedge clock_in);
    rd_en_in = 1'b0;
    chk(rdata_out, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // Ceiling well above the hundred or so cycles the sequence needs
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    idle(10);
    rstn_in = 1'b1;
    chk({4'h0, dport}, 8'h0f);
    chk(f_oe | f_pu | s_oe | s_pu, 8'h00);
    rdc(MPP_ADDR_WAKE_EN, 8'h00);
    rdc(MPP_ADDR_CTL_TWO, 8'h00);
    rdc(MPP_ADDR_L_DATA, 8'h00);
    rdc(MPP_ADDR_L_CFG, 8'h00);
    rdc(MPP_ADDR_G_DATA, 8'h00);
    rdc(MPP_ADDR_G_CFG, 8'h00);
    rdc(MPP_ADDR_CTL_ONE, 8'h00);
    rdc(MPP_ADDR_STATUS, 8'h00);
    rdc(MPP_ADDR_D_DATA, 8'h0f);
    rdc(8'hd3, MPP_RD_UNMAPPED);
    // First port: all four pad modes at once
    f_en = 8'h07;
    f_val = 8'h02;
    wr(MPP_ADDR_L_CFG, 8'hf0);
    wr(MPP_ADDR_L_DATA, 8'hcc);
    chk(f_oe, 8'hf0);
    chk(f_out & 8'hf0, 8'hc0);
    chk(f_pu, 8'h0c);
    rdc(MPP_ADDR_L_DATA, 8'hcc);
    rdc(MPP_ADDR_L_CFG, 8'hf0);
    wr(MPP_ADDR_L_PINS, 8'hff);
    idle(3);
    rdc(MPP_ADDR_L_PINS, 8'hca);
    wr(MPP_ADDR_WAKE_EN, 8'h0f);
    chk(wake, 8'h0a);
    // Comparator and modulator take over their pins
    f_en = 8'h06;
    wr(MPP_ADDR_CTL_TWO, 8'h07);
    idle(3);
    chk({6'h0, cmp_p, cmp_m}, 8'h01);
    chk(f_oe & 8'h87, 8'h81);
    chk(f_out & 8'h81, 8'h01);
    chk(f_pu & 8'h06, 8'h00);
    mod_src = 1'b1;
    cmp_src = 1'b0;
    idle(1);
    chk(f_out & 8'h81, 8'h80);
    // Second port: input-only config bits and pad modes
    wr(MPP_ADDR_G_CFG, 8'hff);
    rdc(MPP_ADDR_G_CFG, 8'h3f);
    chk(s_oe, 8'h3f);
    wr(MPP_ADDR_G_CFG, 8'hcc);
    rdc(MPP_ADDR_G_CFG, 8'h0c);
    s_en = 8'hf1;
    s_val = 8'h50;
    wr(MPP_ADDR_G_DATA, 8'h0a);
    chk({7'h0, halt}, 8'h00);
    chk(s_oe, 8'h0c);
    chk(s_out & 8'h0c, 8'h08);
    chk(s_pu, 8'h02);
    rdc(MPP_ADDR_G_DATA, 8'h0a);
    idle(3);
    rdc(MPP_ADDR_G_PINS, 8'h5a);
    // Halt request is a single pulse
    wr(MPP_ADDR_G_DATA, 8'h8a);
    chk({7'h0, halt}, 8'h01);
    idle(1);
    chk({7'h0, halt}, 8'h00);
    // Output port, then reset in mid-run
    wr(MPP_ADDR_D_DATA, 8'h05);
    chk({4'h0, dport}, 8'h05);
    rdc(MPP_ADDR_D_DATA, 8'h05);
    @(negedge clock_in);
    rstn_in = 1'b0;
    #1;
    chk({4'h0, dport}, 8'h0f);
    chk(f_oe | f_pu | s_oe | s_pu, 8'h00);
    idle(2);
    rstn_in = 1'b1;
    // Input-only port
    in_val = 4'h9;
    idle(3);
    chk({4'h0, in_sync}, 8'h09);
    in_val = 4'h6;
    idle(3);
    chk({4'h0, in_sync}, 8'h06);
    // Second port alternate inputs, each level held several cycles
    s_en = 8'he9;
    s_val = 8'h48;
    wr(MPP_ADDR_STATUS, 8'h01);
    wr(MPP_ADDR_CTL_ONE, 8'h01);
    idle(3);
    chk({3'h0, sdi, sck, tmr, hrst, xint}, 8'h14);
    s_val = 8'ha1;
    idle(3);
    chk({3'h0, sdi, sck, tmr, hrst, xint}, 8'h0b);
    wr(MPP_ADDR_STATUS, 8'h00);
    chk({7'h0, xint}, 8'h00);
    // Alternate outputs beside plain pins 2 and 1
    wr(MPP_ADDR_G_CFG, 8'h06);
    s_en = 8'hc1;
    wr(MPP_ADDR_CTL_ONE, 8'h07);
    chk(s_oe & 8'h3e, 8'h3e);
    chk(s_out & 8'h3e, 8'h18);
    sdo_src = 1'b0;
    sck_src = 1'b1;
    tmr_src = 1'b0;
    idle(1);
    chk(s_out & 8'h3e, 8'h20);
    // Crystal option turns pin 7 into the oscillator output
    s_en = 8'h41;
    xtal = 1'b1;
    idle(3);
    chk({5'h0, s_oe[7], s_out[7], hrst}, 8'h06);
    osc_src = 1'b0;
    idle(1);
    chk({7'h0, s_out[7]}, 8'h00);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
